// file: include/mdrv_pkg.sv
package mdrv_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_BUS_ID  = 8'h00;
	localparam logic [7:0] REG_BRIDGE  = 8'h01;
	localparam logic [7:0] REG_FAULT   = 8'h02;
	localparam logic [7:0] REG_STATUS1 = 8'h03;
	localparam logic [7:0] REG_CHANNEL_FAULT_STATUS = 8'h04;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] BUS_ID_RESET    = 7'h60;
	localparam logic [7:0] BRIDGE_RESET    = 8'h00;
	localparam logic [7:0] FAULT_CTL_RESET = 8'h00;
	localparam logic       SLEW_RESET      = 1'b0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FC_CLEAR      = 7;
	localparam int FC_PIN_DIS    = 6;
	localparam int FC_OCP_LATCH  = 3;
	localparam int FC_OLD_NOFLAG = 1;
	localparam int FC_OLD_HIZ    = 0;
	localparam logic [7:0] FC_WMASK = 8'hdf;
	localparam int ST_SLEW  = 6;
	localparam int ST_FAULT = 4;
	localparam int ST_OCP   = 3;
	localparam int ST_OLD   = 2;
	localparam int ST_TSD   = 1;
	localparam int ST_UVLO  = 0;
	localparam int BC_MODE_LSB = 0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS       = 8;
	localparam int RETRY_NS     = 1000000;
	localparam int RETRY_CYCLES = RETRY_NS / CLK_NS;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_4PIN  = 2'h0,
		MODE_2PIN  = 2'h1,
		MODE_PAR   = 2'h2,
		MODE_INDEP = 2'h3
	} bridge_mode_e;

	typedef enum logic [8:0] {
		S_IDLE      = 9'h001,
		S_ADDR      = 9'h002,
		S_ADDR_ACK  = 9'h004,
		S_INDEX     = 9'h008,
		S_INDEX_ACK = 9'h010,
		S_DATA      = 9'h020,
		S_DATA_ACK  = 9'h040,
		S_TX        = 9'h080,
		S_TX_ACK    = 9'h100
	} link_state_e;

endpackage

// file: rtl/sync2.sv
`timescale 1ns/1ns
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,    // System clock
	input  wire logic             resetn, // Async reset, active low
	input  wire logic [WIDTH-1:0] din,    // Asynchronous input
	output logic      [WIDTH-1:0] dout    // Synchronised output
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;

	sync_s st_q;
	sync_s st_d;

	if (WIDTH < 1) begin : g_width_check
		$error("sync2: WIDTH must be at least 1");
	end

	always_comb begin
		st_d.meta   = din;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.stable;
endmodule

// file: rtl/motor_link_ctrl.sv
`timescale 1ns/1ns
module motor_link_ctrl import mdrv_pkg::*; #(
	parameter int RETRY_CYC = RETRY_CYCLES
) (
	input  wire logic       clk,           // 125 MHz system clock
	input  wire logic       resetn,        // Async reset, active low
	input  wire logic       sleep_pin_n,   // Sleep pin, low puts device to sleep
	input  wire logic       scl_in,        // Bus clock from master
	input  wire logic       sda_in,        // Bus data level
	output logic            sda_out,       // Bus data drive value (always low)
	output logic            sda_oe,        // Bus data pull-low enable
	input  wire logic       fault_pin_in,  // Fault flag pin level
	output logic            fault_pin_out, // Fault flag drive value (always low)
	output logic            fault_pin_oe,  // Fault flag pull-low enable
	input  wire logic       supply_uv,     // Supply undervoltage comparator
	input  wire logic       thermal_sd,    // Thermal shutdown comparator
	input  wire logic [3:0] ocp_det,       // Overcurrent per half-bridge
	input  wire logic [3:0] old_det,       // Open load per half-bridge
	output logic [3:0]      half_hiz,      // Half-bridge Hi-Z command
	output logic            core_en,       // Internal circuits enable
	output logic [7:0]      bridge_cfg,    // Bridge control register
	output logic [7:0]      fault_cfg,     // Fault control register
	output logic            slew_sel       // Slew rate select
);
	localparam int RW = $clog2(RETRY_CYC + 1);

	if (RETRY_CYC < 2) begin : g_retry_check
		$error("motor_link_ctrl: RETRY_CYC must be at least 2");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		link_state_e fsm;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  ptr;
		logic        sda_oe;
		logic [6:0]  addr;
		logic [7:0]  bctl;
		logic [7:0]  fctl;
		logic        slr;
		logic        uvlo_f;
		logic        tsd_f;
		logic [3:0]  ocp_f;
		logic [3:0]  ocp_hold;
		logic [3:0]  old_f;
		logic [RW-1:0] retry;
		logic        scl_d;
		logic        sda_d;
		logic [3:0]  hiz;
		logic        fault_oe;
		logic [1:0]  oe_hist;
		logic        core_en;
	} ctrl_s;

	localparam ctrl_s ST_RST = '{fsm: S_IDLE, addr: BUS_ID_RESET, bctl: BRIDGE_RESET,
		fctl: FAULT_CTL_RESET, slr: SLEW_RESET, scl_d: 1'b1, sda_d: 1'b1, hiz: 4'hf, default: '0};

	ctrl_s st_q;
	ctrl_s st_d;

	logic       scl_s, sda_s, pin_s, awake, uv_s, tsd_s;
	logic [3:0] ocp_s, old_s;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	sync2 #(.WIDTH(14)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.din    ({scl_in, sda_in, fault_pin_in, sleep_pin_n, supply_uv, thermal_sd, ocp_det, old_det}),
		.dout   ({scl_s, sda_s, pin_s, awake, uv_s, tsd_s, ocp_s, old_s})
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] spread(input logic [1:0] mode, input logic [3:0] f);
		unique case (bridge_mode_e'(mode))
			MODE_4PIN, MODE_2PIN: spread = {{2{|f[3:2]}}, {2{|f[1:0]}}};
			MODE_PAR:             spread = {4{|f}};
			MODE_INDEP:           spread = f;
		endcase
	endfunction

	function automatic logic [7:0] rd_reg(input ctrl_s s, input logic [7:0] idx, input logic flt);
		rd_reg = 8'h00;
		unique case (idx)
			REG_BUS_ID:  rd_reg = {1'b0, s.addr};
			REG_BRIDGE:  rd_reg = s.bctl;
			REG_FAULT:   rd_reg = s.fctl & FC_WMASK;
			REG_STATUS1: begin
				rd_reg[ST_SLEW]  = s.slr;
				rd_reg[ST_FAULT] = flt;
				rd_reg[ST_OCP]   = |s.ocp_f;
				rd_reg[ST_OLD]   = |s.old_f;
				rd_reg[ST_TSD]   = s.tsd_f;
				rd_reg[ST_UVLO]  = s.uvlo_f;
			end
			REG_CHANNEL_FAULT_STATUS: rd_reg = {s.old_f, s.ocp_f};
			default:     rd_reg = 8'h00;
		endcase
	endfunction

	logic fault_pin_disable, fault_any, start, stop, rise, fall, detach;
	logic [7:0] rd_now, rd_next;

	assign fault_pin_disable    = st_q.fctl[FC_PIN_DIS];
	assign fault_any = uv_s | tsd_s | (|st_q.ocp_hold) | ((|st_q.old_f) & ~st_q.fctl[FC_OLD_NOFLAG]);
	assign start     = scl_s & st_q.scl_d & st_q.sda_d & ~sda_s;
	assign stop      = scl_s & st_q.scl_d & ~st_q.sda_d & sda_s;
	assign rise      = scl_s & ~st_q.scl_d;
	assign fall      = ~scl_s & st_q.scl_d;
	// Own fault drive still shows on the synchronised pin for two clocks
	assign detach    = fault_pin_disable & ~pin_s & ~st_q.oe_hist[1];
	assign rd_now    = rd_reg(st_q, st_q.ptr, st_q.fault_oe | fault_any);
	assign rd_next   = rd_reg(st_q, st_q.ptr + 8'h01, st_q.fault_oe | fault_any);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d       = st_q;
		st_d.scl_d = scl_s;
		st_d.sda_d = sda_s;

		// Fault flags: a new event always wins over a clear
		st_d.uvlo_f   = st_q.uvlo_f | uv_s;
		st_d.tsd_f    = st_q.tsd_f | tsd_s;
		st_d.ocp_f    = st_q.ocp_f | ocp_s;
		st_d.ocp_hold = st_q.ocp_hold | ocp_s;
		st_d.old_f    = st_q.old_f | old_s;
		if (|st_q.ocp_hold && !st_q.fctl[FC_OCP_LATCH]) begin
			if (st_q.retry == RW'(RETRY_CYC - 1)) begin
				st_d.retry    = '0;
				st_d.ocp_hold = ocp_s;
			end else begin
				st_d.retry = st_q.retry + RW'(1);
			end
		end else begin
			st_d.retry = '0;
		end
		if (st_q.fctl[FC_CLEAR]) begin
			st_d.fctl[FC_CLEAR] = 1'b0;
			st_d.uvlo_f = uv_s;
			st_d.tsd_f  = tsd_s;
			st_d.ocp_f  = ocp_s;
			if (st_q.fctl[FC_OCP_LATCH]) begin
				st_d.ocp_hold = ocp_s;
			end
		end

		// Outputs toward pins and bridges
		st_d.fault_oe = fault_any & ~fault_pin_disable;
		st_d.oe_hist  = {st_q.oe_hist[0], st_q.fault_oe};
		st_d.core_en  = ~uv_s;
		if (uv_s || tsd_s) begin
			st_d.hiz = 4'hf;
		end else begin
			st_d.hiz = spread(st_q.bctl[BC_MODE_LSB +: 2],
				st_q.ocp_hold | (st_q.fctl[FC_OLD_HIZ] ? st_q.old_f : 4'h0));
		end

		// Bus transfer engine
		if (detach || stop) begin
			st_d.fsm    = S_IDLE;
			st_d.sda_oe = 1'b0;
		end else if (start) begin
			st_d.fsm    = S_ADDR;
			st_d.cnt    = 4'h0;
			st_d.sda_oe = 1'b0;
		end else begin
			unique case (st_q.fsm)
				S_IDLE: begin
					st_d.sda_oe = 1'b0;
				end
				S_ADDR, S_INDEX, S_DATA: begin
					if (rise) begin
						st_d.sh  = {st_q.sh[6:0], sda_s};
						st_d.cnt = st_q.cnt + 4'h1;
					end else if (fall && st_q.cnt == 4'h8) begin
						st_d.cnt = 4'h0;
						if (st_q.fsm == S_ADDR) begin
							if (st_q.sh[7:1] == st_q.addr) begin
								st_d.sda_oe = 1'b1;
								st_d.fsm    = S_ADDR_ACK;
							end else begin
								st_d.fsm = S_IDLE;
							end
						end else if (st_q.fsm == S_INDEX) begin
							st_d.ptr    = st_q.sh;
							st_d.sda_oe = 1'b1;
							st_d.fsm    = S_INDEX_ACK;
						end else begin
							st_d.sda_oe = 1'b1;
							st_d.fsm    = S_DATA_ACK;
							unique case (st_q.ptr)
								REG_BUS_ID:  st_d.addr = st_q.sh[6:0];
								REG_BRIDGE:  st_d.bctl = st_q.sh;
								REG_FAULT:   st_d.fctl = st_q.sh & FC_WMASK;
								REG_STATUS1: st_d.slr  = st_q.sh[ST_SLEW];
								default:     st_d.bctl = st_q.bctl;
							endcase
						end
					end
				end
				S_ADDR_ACK: begin
					if (fall) begin
						if (st_q.sh[0]) begin
							st_d.sh     = rd_now;
							st_d.sda_oe = ~rd_now[7];
							st_d.cnt    = 4'h0;
							st_d.fsm    = S_TX;
						end else begin
							st_d.sda_oe = 1'b0;
							st_d.fsm    = S_INDEX;
						end
					end
				end
				S_INDEX_ACK: begin
					if (fall) begin
						st_d.sda_oe = 1'b0;
						st_d.fsm    = S_DATA;
					end
				end
				S_DATA_ACK: begin
					if (fall) begin
						st_d.sda_oe = 1'b0;
						st_d.fsm    = S_IDLE;
					end
				end
				S_TX: begin
					if (rise) begin
						st_d.cnt = st_q.cnt + 4'h1;
					end else if (fall) begin
						if (st_q.cnt == 4'h8) begin
							st_d.sda_oe = 1'b0;
							st_d.fsm    = S_TX_ACK;
						end else begin
							st_d.sh     = {st_q.sh[6:0], 1'b0};
							st_d.sda_oe = ~st_q.sh[6];
						end
					end
				end
				S_TX_ACK: begin
					if (rise && sda_s) begin
						st_d.fsm = S_IDLE;
					end else if (fall) begin
						st_d.ptr    = st_q.ptr + 8'h01;
						st_d.sh     = rd_next;
						st_d.sda_oe = ~rd_next[7];
						st_d.cnt    = 4'h0;
						st_d.fsm    = S_TX;
					end
				end
			endcase
		end

		// Sleep pin acts as a full reset, restoring the default address
		if (!awake) begin
			st_d = ST_RST;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign sda_out       = 1'b0;
	assign sda_oe        = st_q.sda_oe;
	assign fault_pin_out = 1'b0;
	assign fault_pin_oe  = st_q.fault_oe;
	assign half_hiz      = st_q.hiz;
	assign core_en       = st_q.core_en;
	assign bridge_cfg    = st_q.bctl;
	assign fault_cfg     = st_q.fctl;
	assign slew_sel      = st_q.slr;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	logic [6:0] sh_low;
	assign sh_low = st_q.sh[6:0];

	sequence s_clr_issued;
		awake && st_q.fctl[FC_CLEAR] && !uv_s;
	endsequence
	sequence s_flags_cleared;
		!st_q.fctl[FC_CLEAR] && !st_q.uvlo_f;
	endsequence

	a_addr_ack: assert property (awake && !detach && !stop && !start && st_q.fsm == S_ADDR && fall
		&& st_q.cnt == 4'h8 && st_q.sh[7:1] == st_q.addr |=> st_q.sda_oe && st_q.fsm == S_ADDR_ACK)
		else $error("address match not acknowledged");
	a_index_ack: assert property (awake && !detach && !stop && !start && st_q.fsm == S_INDEX && fall
		&& st_q.cnt == 4'h8 |=> st_q.sda_oe && st_q.fsm == S_INDEX_ACK)
		else $error("register index not acknowledged");
	a_tx_drive: assert property (st_q.fsm == S_TX |-> st_q.sda_oe == ~st_q.sh[7])
		else $error("read data bit not driven");
	a_nack_release: assert property (awake && !detach && !stop && !start && st_q.fsm == S_TX_ACK
		&& rise && sda_s |=> !st_q.sda_oe && st_q.fsm == S_IDLE)
		else $error("bus not released after nack");
	a_addr_update: assert property (awake && !detach && !stop && !start && st_q.fsm == S_DATA && fall
		&& st_q.cnt == 4'h8 && st_q.ptr == REG_BUS_ID |=> st_q.addr == $past(sh_low))
		else $error("bus address not updated");
	a_pin_disable: assert property (fault_pin_disable |=> !st_q.fault_oe)
		else $error("fault pin driven while disabled");
	a_pin_enable: assert property (awake && !fault_pin_disable && fault_any |=> st_q.fault_oe)
		else $error("fault pin not driven on fault");
	a_bus_detach: assert property (awake && detach |=> st_q.fsm == S_IDLE && !st_q.sda_oe)
		else $error("device stayed on bus while detached");
	a_reserved_zero: assert property ((rd_now[7:5] & {st_q.ptr == REG_BUS_ID || st_q.ptr == REG_STATUS1,
		1'b0, st_q.ptr == REG_FAULT || st_q.ptr == REG_STATUS1}) == 3'b000)
		else $error("reserved bit reads nonzero");
	a_old_latch: assert property (awake && $past(awake)
		|-> (st_q.old_f & $past(st_q.old_f)) == $past(st_q.old_f))
		else $error("open load flag lost");
	a_clear_done: assert property (s_clr_issued |=> s_flags_cleared)
		else $error("clear faults did not complete");
	a_uvlo_off: assert property (awake && uv_s |=> st_q.hiz == 4'hf && !st_q.core_en && st_q.uvlo_f)
		else $error("undervoltage not handled");
	a_tsd_off: assert property (awake && tsd_s |=> st_q.hiz == 4'hf && st_q.tsd_f)
		else $error("thermal shutdown not handled");
	a_ocp_par: assert property (awake && |ocp_s && st_q.bctl[1:0] == MODE_PAR && $stable(st_q.bctl)
		|=> ##1 st_q.hiz == 4'hf)
		else $error("parallel overcurrent not Hi-Z");
	a_old_hiz: assert property (awake && !uv_s && !tsd_s && st_q.fctl[FC_OLD_HIZ]
		&& st_q.bctl[1:0] == MODE_INDEP |=> (st_q.hiz & $past(st_q.old_f)) == $past(st_q.old_f))
		else $error("open load bridge not Hi-Z");
endmodule

// file: tb/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
	input  wire logic       clk,  // System clock
	input  wire logic       sda,  // Resolved data line
	output logic            scl,  // Bus clock, idle high
	output logic            oe,   // Pull data line low
	output logic            stb,  // Result strobe
	output logic            kind, // Result kind, 1 byte, 0 ack
	output logic [7:0]      val   // Result value
);
	// ----------------------------------------------------------------
	// Bus cycles, one SCL period is 20 clocks
	// ----------------------------------------------------------------
	initial begin
		scl = 1'b1;
		oe = 1'b0;
		stb = 1'b0;
		kind = 1'b0;
		val = 8'h00;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic bitio(input logic b, output logic r);
		@(posedge clk) oe <= ~b;
		tk(5);
		scl <= 1'b1;
		tk(5);
		r = sda;
		tk(5);
		scl <= 1'b0;
		tk(4);
	endtask

	task automatic emit(input logic k, input logic [7:0] v);
		@(posedge clk);
		stb <= 1'b1;
		kind <= k;
		val <= v;
		@(posedge clk) stb <= 1'b0;
	endtask

	// Also serves as repeated START
	task automatic start;
		@(posedge clk) oe <= 1'b0;
		tk(5);
		scl <= 1'b1;
		tk(5);
		oe <= 1'b1;
		tk(5);
		scl <= 1'b0;
		tk(4);
	endtask

	task automatic stop;
		@(posedge clk) oe <= 1'b1;
		tk(5);
		scl <= 1'b1;
		tk(5);
		oe <= 1'b0;
		tk(10);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitio(d[i], r);
		bitio(1'b1, r);
		ack = ~r;
		emit(1'b0, {7'h00, ack});
	endtask

	task automatic rbyte(output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bitio(1'b1, r);
			d = {d[6:0], r};
		end
		bitio(1'b1, r); // NACK ends the read
		emit(1'b1, d);
	endtask

	task automatic wr_reg(input logic [6:0] a, input logic [7:0] i, input logic [7:0] d);
		logic k;
		start;
		wbyte({a, 1'b0}, k);
		if (k) wbyte(i, k);
		if (k) wbyte(d, k);
		stop;
	endtask

	task automatic rd_reg(input logic [6:0] a, input logic [7:0] i);
		logic       k;
		logic [7:0] d;
		start;
		wbyte({a, 1'b0}, k);
		if (k) wbyte(i, k);
		if (k) begin
			start;
			wbyte({a, 1'b1}, k);
		end
		if (k) rbyte(d);
		stop;
	endtask
endmodule

// file: tb/motor_driver_i2c_ctrl_faults_test.sv
`timescale 1ns/1ns
module motor_driver_i2c_ctrl_faults_test import mdrv_pkg::*;;
	logic       clk = 0, resetn = 0, sleep_pin_n = 1, uv = 0, thermal_shutdown = 0, low_q = 0;
	logic [3:0] overcurrent_guard = 4'h0, old = 4'h0, hiz;
	logic       sda_oe, fpin_oe, m_oe, scl, stb, kind, core_en, slew, sda_o, fpin_o;
	logic [7:0] val, bcfg, fcfg;
	int         miscompares = 0, compares = 0;
	logic       exp_ack[$];
	logic [7:0] exp_byte[$];
	wire        sda = ~(sda_oe & ~sda_o) & ~m_oe;
	wire        fpin = ~(fpin_oe & ~fpin_o) & ~low_q;

	always #4 clk = ~clk;

	motor_link_ctrl #(.RETRY_CYC(8)) u_dut (.clk(clk), .resetn(resetn), .sleep_pin_n(sleep_pin_n),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe), .fault_pin_in(fpin), .fault_pin_out(fpin_o),
		.fault_pin_oe(fpin_oe), .supply_uv(uv), .thermal_sd(thermal_shutdown), .ocp_det(overcurrent_guard), .old_det(old),
		.half_hiz(hiz), .core_en(core_en), .bridge_cfg(bcfg), .fault_cfg(fcfg), .slew_sel(slew));

	i2c_master_model u_master (.clk(clk), .sda(sda), .scl(scl), .oe(m_oe), .stb(stb), .kind(kind), .val(val));

	// ----------------------------------------------------------------
	// Compare and bus helpers
	// ----------------------------------------------------------------
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		cmp({7'h00, got}, {7'h00, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Writes only ever target four of the five defined registers, never the channel fault status
	task automatic wr(input logic [6:0] a, input logic [7:0] i, input logic [7:0] d, input logic k);
		exp_ack.push_back(k);
		if (k) begin
			exp_ack.push_back(1'b1);
			exp_ack.push_back(1'b1);
		end
		u_master.wr_reg(a, i, d);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] i, input logic k, input logic [7:0] d);
		exp_ack.push_back(k);
		if (k) begin
			exp_ack.push_back(1'b1);
			exp_ack.push_back(1'b1);
			exp_byte.push_back(d);
		end
		u_master.rd_reg(a, i);
		cmp_bit(sda_oe, 1'b0);
	endtask

	always @(posedge clk) begin
		if (stb === 1'b1 && kind === 1'b1)
			cmp(val, exp_byte.size() ? exp_byte.pop_front() : 8'hxx);
		else if (stb === 1'b1)
			cmp_bit(val[0], exp_ack.size() ? exp_ack.pop_front() : 1'bx);
	end

	task automatic wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#400000;
		miscompares++;
		wrap_up;
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [6:0] na;
		logic [7:0] rv;
		logic [7:0] rst [6];
		logic [3:0] hz [4];
		void'($urandom(64));
		rst = '{8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		hz = '{4'h3, 4'h3, 4'hf, 4'h1};
		cyc(4);
		resetn <= 1'b1;
		cyc(4);
		for (int i = 0; i < 6; i++) rd(7'h60, 8'(i), 1'b1, rst[i]);
		rd(7'h61, REG_BUS_ID, 1'b0, 8'h00);
		rv = 8'($urandom);
		wr(7'h60, REG_BRIDGE, rv, 1'b1);
		rd(7'h60, REG_BRIDGE, 1'b1, rv);
		cmp(bcfg, rv);
		rv = 8'($urandom) & 8'h5f;
		wr(7'h60, REG_FAULT, rv, 1'b1);
		rd(7'h60, REG_FAULT, 1'b1, rv);
		cmp(fcfg, rv);
		wr(7'h60, REG_STATUS1, 8'hff, 1'b1);
		rd(7'h60, REG_STATUS1, 1'b1, 8'h40);
		cmp_bit(slew, 1'b1);
		na = 7'($urandom % 95 + 1);
		wr(7'h60, REG_BUS_ID, {1'b0, na}, 1'b1);
		rd(7'h60, REG_BUS_ID, 1'b0, 8'h00);
		rd(na, REG_BUS_ID, 1'b1, {1'b0, na});
		wr(na, REG_FAULT, 8'h40, 1'b1);
		low_q <= 1'b1;
		cyc(4);
		rd(na, REG_BUS_ID, 1'b0, 8'h00);
		low_q <= 1'b0;
		cyc(4);
		wr(na, REG_BRIDGE, 8'h03, 1'b1);
		wr(na, REG_FAULT, 8'h01, 1'b1);
		old <= 4'h2;
		cyc(8);
		cmp({4'h0, hiz}, 8'h02);
		cmp_bit(fpin_oe, 1'b1);
		old <= 4'h0;
		wr(na, REG_FAULT, 8'h00, 1'b1);
		cyc(4);
		cmp({4'h0, hiz}, 8'h00);
		cmp_bit(fpin_oe, 1'b1);
		wr(na, REG_FAULT, 8'h40, 1'b1);
		cyc(4);
		cmp_bit(fpin_oe, 1'b0);
		wr(na, REG_FAULT, 8'h00, 1'b1);
		cyc(4);
		cmp_bit(fpin_oe, 1'b1);
		rd(na, REG_CHANNEL_FAULT_STATUS, 1'b1, 8'h20);
		uv <= 1'b1;
		cyc(8);
		cmp({4'h0, hiz}, 8'h0f);
		cmp_bit(core_en, 1'b0);
		uv <= 1'b0;
		thermal_shutdown <= 1'b1;
		cyc(8);
		cmp({4'h0, hiz}, 8'h0f);
		cmp_bit(core_en, 1'b1);
		thermal_shutdown <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			wr(na, REG_BRIDGE, 8'(m), 1'b1);
			overcurrent_guard <= 4'h1;
			cyc(8);
			cmp({4'h0, hiz}, {4'h0, hz[m]});
			overcurrent_guard <= 4'h0;
			cyc(30);
			cmp({4'h0, hiz}, 8'h00);
		end
		rd(na, REG_STATUS1, 1'b1, 8'h5f);
		wr(na, REG_FAULT, 8'h80, 1'b1);
		cyc(2);
		cmp(fcfg, 8'h00);
		rd(na, REG_STATUS1, 1'b1, 8'h54);
		sleep_pin_n <= 1'b0;
		cyc(6);
		cmp_bit(fpin_oe, 1'b0);
		sleep_pin_n <= 1'b1;
		cyc(6);
		rd(7'h60, REG_BUS_ID, 1'b1, 8'h60);
		wrap_up;
	end
endmodule
